// File: bench/absolute_encoder_alarm_logic_tb.sv
// self-checking bench joining device and host ends through the link
`timescale 1ns/1ps
`default_nettype none
module absolute_encoder_alarm_logic_tb
  import aeal_pkg::*;
  ();
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              motor_running, servo_drive, abs_sel, b12, bl, ba, gen, bk, mc, df, os;
  logic              sen_d;
  logic [FSW_W-1:0]  fsw;
  aeal_alarm_e       alarm_id;
  int                bad_count, compares, i;
  aeal_alarm_e       ids [4] = '{AL_DATA, AL_BATTERY, AL_BATTERY, AL_SUMCHECK};
  int                fbs [4] = '{FB_DATA, FB_BATTERY, FB_BATTERY, FB_SUMCHECK};
  aeal_link_if link ();
  aeal_device aeal_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .abs_encoder_sel(abs_sel), .enc_12bit_sel(b12), .function_select_word(fsw),
    .enc_general_fault(gen), .backup_supply_lost(bk), .memory_check_fault(mc),
    .battery_below_limit(bl), .battery_absent(ba), .data_fault(df),
    .overspeed_fault(os), .alarm_id(alarm_id));
  aeal_host aeal_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .motor_running(motor_running),
    .servo_drive(servo_drive), .link(link));
  aeal_link_checker aeal_link_checker_i (.pclk(pclk), .presetn(presetn),
    .sensor_enable_input(link.sensor_enable_input), .serial_request(link.serial_request),
    .alarm_code(link.alarm_code), .alarm_summary_on(link.alarm_summary_on),
    .serial_bit(link.serial_bit), .serial_first(link.serial_first),
    .serial_last(link.serial_last));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : chk
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one idle cycle before each setup keeps psel from being driven twice at one edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h0, 32'h1, "apb answer timeout");
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rdchk
  task ctrl(input logic [31:0] v);
    apb(1'b1, OFS_CTRL, v);
    tick(4);
  endtask : ctrl
  task wait_last;
    int n;
    n = 0;
    while (link.serial_last !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      chk(32'h0, 32'h1, "serial frame timeout");
      print_verdict;
    end
    tick(1);
  endtask : wait_last
  task power;
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
  endtask : power
  // enable must never drop while the servo is still driven
  always @(posedge pclk) begin
    if (presetn && sen_d && !link.sensor_enable_input && servo_drive)
      chk(32'h1, 32'h0, "enable dropped with servo on");
    sen_d <= link.sensor_enable_input;
  end
  initial begin
    #(50 * 20000);
    chk(32'h0, 32'h1, "run timeout");
    print_verdict;
  end
  initial begin
    {psel, penable, pwrite, motor_running, abs_sel, b12, bl, ba, gen, bk, mc, df, os} = '0;
    paddr = 8'h00; pwdata = 32'h0; fsw = 8'h00; presetn = 1'b0;
    bad_count = 0; compares = 0;
    tick(6);
    presetn <= 1'b1;
    tick(2);
    rdchk(OFS_STATUS, 32'h08, "status after reset");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    ctrl(32'h1);
    gen <= 1'b1;
    tick(3);
    rdchk(OFS_STATUS, 32'h08, "incremental encoder");
    abs_sel <= 1'b1;
    tick(3);
    rdchk(OFS_STATUS, 32'h00, "general alarm");
    chk(32'(alarm_id), 32'(AL_GENERAL), "general id");
    rdchk(OFS_INT_STAT, 32'h1, "alarm event");
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, OFS_INT_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, OFS_INT_STAT, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    gen <= 1'b0;
    tick(3);
    rdchk(OFS_STATUS, 32'h00, "alarm latched");
    ctrl(32'h0);
    rdchk(OFS_STATUS, 32'h08, "enable drop clears");
    ctrl(32'h1);
    rdchk(OFS_STATUS, 32'h08, "clean restart");
    $display("test general done");
    for (i = 0; i < 4; i++) begin
      {mc, ba, bl, df} <= 4'(1 << i);
      tick(3);
      rdchk(OFS_STATUS, (i == 3) ? 32'h00 : 32'h08, "while running");
      ctrl(32'h3);
      wait_last;
      wait_last;
      rdchk(OFS_SERIAL, 32'(1) << fbs[i], "serial word");
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk(rd & (32'(1) << IRQ_SERIAL), 32'(1) << IRQ_SERIAL, "serial event");
      {mc, ba, bl, df} <= 4'h0;
      ctrl(32'h0);
      ctrl(32'h1);
      rdchk(OFS_STATUS, 32'h00, "alarm at restart");
      chk(32'(alarm_id), 32'(ids[i]), "deferred id");
      ctrl(32'h0);
      rdchk(OFS_STATUS, 32'h08, "deferred cleared");
      ctrl(32'h1);
    end
    $display("test deferred done");
    bk <= 1'b1;
    tick(3);
    rdchk(OFS_STATUS, 32'h08, "backup without 12-bit");
    b12 <= 1'b1;
    tick(3);
    chk(32'(alarm_id), 32'(AL_BACKUP), "backup id");
    bk <= 1'b0;
    fsw <= 8'h02;
    ctrl(32'h0);
    ctrl(32'h1);
    rdchk(OFS_STATUS, 32'h00, "toggle does not clear");
    chk(32'(alarm_id), 32'(AL_GENERAL), "latched at restart");
    power;
    rdchk(OFS_STATUS, 32'h08, "power clears");
    fsw <= 8'h00;
    $display("test backup done");
    os <= 1'b1;
    tick(3);
    rdchk(OFS_STATUS, 32'h05, "overspeed code");
    chk(32'(alarm_id), 32'(AL_OVERSPEED), "overspeed id");
    os <= 1'b0;
    power;
    motor_running <= 1'b1;
    ctrl(32'h5);
    rdchk(OFS_STATUS, 32'h18, "servo on");
    ctrl(32'h0);
    tick(4);
    rdchk(OFS_STATUS, 32'h08, "servo off");
    chk({31'h0, link.sensor_enable_input}, 32'h0, "enable off");
    $display("test servo done");
    print_verdict;
  end
endmodule : absolute_encoder_alarm_logic_tb
`default_nettype wire

// File: bench/aeal_link_checker.sv
// assertions on the alarm link between the encoder alarm logic and the host
`timescale 1ns/1ps
`default_nettype none
module aeal_link_checker (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // host to device
  input  wire logic       sensor_enable_input,
  input  wire logic       serial_request,
  // device to host
  input  wire logic [2:0] alarm_code,
  input  wire logic       alarm_summary_on,
  input  wire logic       serial_bit,
  input  wire logic       serial_first,
  input  wire logic       serial_last
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  property p_alarm_code;
    !alarm_summary_on |-> alarm_code inside {3'h0, 3'h5};
  endproperty
  a_alarm_code: assert property (p_alarm_code)
    else $error("alarm code is neither encoder nor overspeed");
  property p_idle_code;
    alarm_summary_on |-> alarm_code == 3'h0;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("code pins driven without an alarm");
  // enable held high for three samples, so no clearing can be in flight
  property p_latched;
    $past(!alarm_summary_on && alarm_code == 3'h0) && $past(sensor_enable_input, 2)
      && $past(sensor_enable_input) && sensor_enable_input |-> !alarm_summary_on;
  endproperty
  a_latched: assert property (p_latched)
    else $error("encoder alarm dropped while enable held");
  property p_clear_cause;
    $rose(alarm_summary_on) && $past(alarm_code) == 3'h0
      |-> !$past(sensor_enable_input) || !$past(sensor_enable_input, 2);
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("alarm cleared without an enable drop");
  // a frame cut by a dropped request legally ends without its last bit
  property p_frame_len;
    serial_first && serial_request ##1 serial_request [*3] |=> serial_last;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("serial frame is not five bits");
  property p_last_cause;
    serial_last |-> $past(serial_first, 4) && !serial_first;
  endproperty
  a_last_cause: assert property (p_last_cause)
    else $error("frame end without a frame start");
  property p_first_gap;
    serial_first |=> !serial_first [*4];
  endproperty
  a_first_gap: assert property (p_first_gap)
    else $error("frame start inside a frame");
  property p_no_request;
    !serial_request [*4] |-> !serial_first;
  endproperty
  a_no_request: assert property (p_no_request)
    else $error("frame started without a request");
  c_frame: cover property (serial_first ##4 serial_last);
  c_raise: cover property ($fell(alarm_summary_on));
  c_clear: cover property ($rose(alarm_summary_on));
endmodule : aeal_link_checker
`default_nettype wire

// File: rtl/aeal_device.sv
// absolute encoder alarm detection, latching and reporting
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - encoder alarms drive code 000, summary off
// - encoder alarms only with absolute encoder selected
// - backup error needs 12-bit encoder, supplies lost
// - memory check abnormality gives sum-check error
// - sum-check while running first shows general
// - sum-check code only after enable or power cycle
// - sum-check visible on serial channel while running
// - battery fault deferred to next enable or power
// - battery fault visible on serial channel
// - low battery or missing battery is fault
// - data fault deferred to next enable or power
// - data fault visible on serial channel
// - select bit chooses enable toggle or power clear
// - host turns servo off before dropping enable, at the same edge if the motor is stopped
// - encoder alarm present at restart gives general error
// - overspeed drives code 101, summary off
module aeal_device
  import aeal_pkg::*;
(
  // clock and reset (reset stands for a drive power cycle)
  input  wire logic             pclk,
  input  wire logic             presetn,
  // link toward the host controller
  aeal_link_if.device           link,
  // encoder configuration
  input  wire logic             abs_encoder_sel,
  input  wire logic             enc_12bit_sel,
  input  wire logic [FSW_W-1:0] function_select_word,
  // raw fault indications from the encoder front end
  input  wire logic             enc_general_fault,
  input  wire logic             backup_supply_lost,
  input  wire logic             memory_check_fault,
  input  wire logic             battery_below_limit,
  input  wire logic             battery_absent,
  input  wire logic             data_fault,
  input  wire logic             overspeed_fault,
  // latched alarm for local display
  output aeal_alarm_e           alarm_id
);
  ////////////////////////////////////////////////////////////////////////
  // qualified faults
  logic f_general;
  logic f_backup;
  logic f_sum;
  logic f_battery;
  logic f_data;
  logic power_cycle_only;

  assign f_general = abs_encoder_sel & enc_general_fault;
  assign f_backup  = abs_encoder_sel & enc_12bit_sel & backup_supply_lost;
  assign f_sum     = abs_encoder_sel & memory_check_fault;
  // comparator trips at BATTERY_LIMIT_MV
  assign f_battery = abs_encoder_sel & (battery_below_limit | battery_absent);
  assign f_data    = abs_encoder_sel & data_fault;
  assign power_cycle_only = function_select_word[FSW_CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // sensor enable edges and power-up restart
  logic sen_q;
  logic power_up;
  logic sen_rise;
  logic sen_fall;
  logic restart;
  logic clear_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= 1'b0;
    end else begin
      sen_q <= link.sensor_enable_input;
    end
  end

  // first cycle after release acts as the power-on evaluation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up <= 1'b1;
    end else begin
      power_up <= 1'b0;
    end
  end

  assign sen_rise  = link.sensor_enable_input & ~sen_q;
  assign sen_fall  = ~link.sensor_enable_input & sen_q;
  assign restart   = sen_rise | power_up;
  assign clear_req = sen_fall & ~power_cycle_only;

  ////////////////////////////////////////////////////////////////////////
  // deferred faults, remembered until the next restart
  // new fault in the restart cycle wins over consumption
  logic pend_sum;
  logic pend_battery;
  logic pend_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_sum     <= 1'b0;
      pend_battery <= 1'b0;
      pend_data    <= 1'b0;
    end else begin
      pend_sum     <= f_sum     | (pend_sum     & ~restart);
      pend_battery <= f_battery | (pend_battery & ~restart);
      pend_data    <= f_data    | (pend_data    & ~restart);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm latch
  aeal_alarm_e next_alarm;
  logic [2:0]  next_code;
  logic        next_summary_on;

  always_comb begin
    next_alarm = alarm_id;
    if (clear_req) begin
      next_alarm = AL_NONE;
    end
    if (next_alarm == AL_NONE) begin
      if (overspeed_fault) begin
        next_alarm = AL_OVERSPEED;
      end else if (restart) begin
        if (pend_sum | f_sum) begin
          next_alarm = AL_SUMCHECK;
        end else if (pend_data | f_data) begin
          next_alarm = AL_DATA;
        end else if (pend_battery | f_battery) begin
          next_alarm = AL_BATTERY;
        end else if (f_backup) begin
          next_alarm = AL_BACKUP;
        end else if (f_general) begin
          next_alarm = AL_GENERAL;
        end
      end else if (f_general) begin
        next_alarm = AL_GENERAL;
      end else if (f_backup) begin
        next_alarm = AL_BACKUP;
      end else if (f_sum) begin
        next_alarm = AL_GENERAL;
      end
    end else if (restart && next_alarm != AL_OVERSPEED) begin
      // still latched because only a power cycle may clear it
      next_alarm = AL_GENERAL;
    end
  end

  always_comb begin
    next_code       = CODE_IDLE;
    next_summary_on = 1'b0;
    unique case (next_alarm)
      AL_NONE: begin
        next_code       = CODE_IDLE;
        next_summary_on = 1'b1;
      end
      AL_GENERAL, AL_BACKUP, AL_SUMCHECK, AL_BATTERY, AL_DATA: begin
        next_code = CODE_ENCODER;
      end
      AL_OVERSPEED: begin
        next_code = CODE_OVERSPEED;
      end
      default: begin
        next_code = CODE_IDLE;
      end
    endcase
  end

  // held until cleared; only reset or a permitted toggle releases it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_id <= AL_NONE;
    end else begin
      alarm_id <= next_alarm;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.alarm_code       <= CODE_IDLE;
      link.alarm_summary_on <= 1'b1;
    end else begin
      link.alarm_code       <= next_code;
      link.alarm_summary_on <= next_summary_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial status channel shows live faults, no restart needed
  logic [FAULT_W-1:0] live_word;

  always_comb begin
    live_word              = '0;
    live_word[FB_DATA]     = f_data;
    live_word[FB_BATTERY]  = f_battery;
    live_word[FB_SUMCHECK] = f_sum;
    live_word[FB_BACKUP]   = f_backup;
    live_word[FB_GENERAL]  = f_general;
  end

  aeal_ser_tx #(
    .W (FAULT_W)
  ) u_ser_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .word      (live_word),
    .enable    (link.serial_request),
    .ser_bit   (link.serial_bit),
    .ser_first (link.serial_first),
    .ser_last  (link.serial_last)
  );
endmodule : aeal_device
`default_nettype wire

// File: rtl/aeal_host.sv
// host controller end: apb registers, enable sequencing, serial receive
`timescale 1ns/1ps
`default_nettype none
module aeal_host
  import aeal_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // motor side
  input  wire logic        motor_running,
  output logic             servo_drive,
  // link toward the alarm logic
  aeal_link_if.host        link
);
  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [CTRL_W-1:0]  ctrl;
  logic [IRQ_W-1:0]   int_stat;
  logic [IRQ_W-1:0]   int_mask;
  logic [FAULT_W-1:0] ser_word;
  logic [FAULT_W-1:0] ser_shift;
  logic               summary_q;
  logic               setup;
  logic               wr;
  logic               mapped;
  logic [IRQ_W-1:0]   ev;

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite;
  assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_STATUS) | (paddr == OFS_SERIAL)
                | (paddr == OFS_INT_STAT) | (paddr == OFS_INT_MASK);

  // one wait-free access: answer is registered during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        unique case (paddr)
          OFS_CTRL:     prdata <= 32'(ctrl);
          OFS_STATUS:   prdata <= 32'({servo_drive, link.alarm_summary_on, link.alarm_code});
          OFS_SERIAL:   prdata <= 32'(ser_word);
          OFS_INT_STAT: prdata <= 32'(int_stat);
          OFS_INT_MASK: prdata <= 32'(int_mask);
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RESET;
      int_mask <= IRQ_RESET;
    end else if (wr) begin
      if (paddr == OFS_CTRL) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFS_INT_MASK) begin
        int_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable sequencing: servo goes off before the enable drops while the motor runs, at the same edge when it is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sensor_enable_input <= 1'b0;
      servo_drive              <= 1'b0;
    end else if (!ctrl[CTRL_SENSOR] && link.sensor_enable_input) begin
      servo_drive <= 1'b0;
      if (!servo_drive || !motor_running) begin
        link.sensor_enable_input <= 1'b0;
      end
    end else begin
      link.sensor_enable_input <= ctrl[CTRL_SENSOR];
      servo_drive              <= ctrl[CTRL_SERVO] & ctrl[CTRL_SENSOR];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial status receive, msb first, latched on the last bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.serial_request <= 1'b0;
      ser_shift           <= '0;
      ser_word            <= '0;
    end else begin
      link.serial_request <= ctrl[CTRL_SERIAL];
      ser_shift           <= {ser_shift[FAULT_W-2:0], link.serial_bit};
      if (link.serial_last) begin
        ser_word <= {ser_shift[FAULT_W-2:0], link.serial_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  assign ev[IRQ_ALARM]  = summary_q & ~link.alarm_summary_on;
  assign ev[IRQ_SERIAL] = link.serial_last & (|{ser_shift[FAULT_W-2:0], link.serial_bit});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_q <= 1'b1;
      int_stat  <= IRQ_RESET;
      irq       <= 1'b0;
    end else begin
      summary_q <= link.alarm_summary_on;
      if (wr && paddr == OFS_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[IRQ_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
      irq <= |(int_stat & int_mask);
    end
  end
endmodule : aeal_host
`default_nettype wire

// File: rtl/aeal_link_if.sv
// wires between the alarm logic and the host motion controller
`timescale 1ns/1ps
`default_nettype none
interface aeal_link_if;
  logic       sensor_enable_input;
  logic       serial_request;
  logic [2:0] alarm_code;
  logic       alarm_summary_on;
  logic       serial_bit;
  logic       serial_first;
  logic       serial_last;

  modport device (
    input  sensor_enable_input,
    input  serial_request,
    output alarm_code,
    output alarm_summary_on,
    output serial_bit,
    output serial_first,
    output serial_last
  );
  modport host (
    output sensor_enable_input,
    output serial_request,
    input  alarm_code,
    input  alarm_summary_on,
    input  serial_bit,
    input  serial_first,
    input  serial_last
  );
endinterface : aeal_link_if
`default_nettype wire

// File: rtl/aeal_pkg.sv
// constants and types shared by both ends of the encoder alarm link
package aeal_pkg;
  // alarm code pins, one bit per code output transistor (1 = on)
  localparam logic [2:0] CODE_ENCODER   = 3'h0;
  localparam logic [2:0] CODE_OVERSPEED = 3'h5;
  localparam logic [2:0] CODE_IDLE      = 3'h0;
  // serial status word layout
  localparam int FAULT_W     = 5;
  localparam int FB_DATA     = 0;
  localparam int FB_BATTERY  = 1;
  localparam int FB_SUMCHECK = 2;
  localparam int FB_BACKUP   = 3;
  localparam int FB_GENERAL  = 4;
  // function select word bit choosing the clearing action
  localparam int FSW_W         = 8;
  localparam int FSW_CLEAR_BIT = 1;
  // battery fault threshold, applied by the analog comparator outside
  localparam int BATTERY_LIMIT_MV = 2800;
  // controller register map (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_SERIAL   = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // control register fields
  localparam int CTRL_SENSOR = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_SERVO  = 2;
  localparam int CTRL_W      = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // interrupt fields
  localparam int IRQ_ALARM  = 0;
  localparam int IRQ_SERIAL = 1;
  localparam int IRQ_W      = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  // latched alarm identity
  typedef enum logic [2:0] {
    AL_NONE, AL_GENERAL, AL_BACKUP, AL_SUMCHECK, AL_BATTERY, AL_DATA, AL_OVERSPEED
  } aeal_alarm_e;
endpackage : aeal_pkg

// File: rtl/aeal_ser_tx.sv
// serial status channel transmitter, msb first, repeating frames
`timescale 1ns/1ps
`default_nettype none
module aeal_ser_tx #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // word to send and channel request
  input  wire logic [W-1:0] word,
  input  wire logic         enable,
  // serial outputs
  output logic              ser_bit,
  output logic              ser_first,
  output logic              ser_last
);
  localparam int CW = (W > 1) ? $clog2(W) : 1;
  logic [CW-1:0] idx;
  logic [W-1:0]  hold;

  // word is captured at frame start so a frame never mixes two samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx       <= '0;
      hold      <= '0;
      ser_bit   <= 1'b0;
      ser_first <= 1'b0;
      ser_last  <= 1'b0;
    end else if (!enable) begin
      idx       <= '0;
      ser_bit   <= 1'b0;
      ser_first <= 1'b0;
      ser_last  <= 1'b0;
    end else begin
      ser_first <= (idx == '0);
      ser_last  <= (idx == CW'(W - 1));
      if (idx == '0) begin
        hold    <= word;
        ser_bit <= word[W-1];
      end else begin
        ser_bit <= hold[CW'(W - 1) - idx];
      end
      idx <= (idx == CW'(W - 1)) ? '0 : idx + 1'b1;
    end
  end
endmodule : aeal_ser_tx
`default_nettype wire
